//--- bench/tsr_frontend_model.sv
// sensing frontend model that answers each slot with a programmed value
module tsr_frontend_model
    import tsr_pkg::*;
#(
    parameter int unsigned DELAY = 5
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         sense_start,
    input  wire logic [3:0]   sense_chan,
    input  wire logic         sense_window,
    input  wire logic [143:0] slot_vals,
    output logic              sense_valid,
    output logic [15:0]       sense_value
);
    timeunit 1ns;
    timeprecision 1ps;

    int         wait_q;
    logic [3:0] chan_q;

    // higher slots answer later, still inside the sensing interval
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 0;
            chan_q <= 4'h0;
            sense_valid <= 1'b0;
            sense_value <= 16'h0000;
        end else begin
            sense_valid <= 1'b0;
            // result lines carry junk outside the answer cycle
            sense_value <= ~sense_value;
            if (sense_start && sense_window) begin
                wait_q <= DELAY + 100 * int'(sense_chan);
                chan_q <= sense_chan;
            end else if (wait_q == 1) begin
                sense_valid <= 1'b1;
                sense_value <= slot_vals[16*chan_q +: 16];
                wait_q <= 0;
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule // tsr_frontend_model

//--- bench/tsr_scan_tb_top.sv
// self-checking bench of the touch scan and report block
module tsr_scan_tb_top
    import tsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PWM_PER = 64 * (int'(PWM_LAST) + 1);

    logic        ref_clk, arst_n, prox_enable, sense_valid, sleep_enable;
    logic        mode_force, mode_force_sleep, rpt_idle_gap;
    logic        buz_enable, buz_idle_level;
    logic [7:0]  chan_enable, prox_combine, active_skip, sleep_skip;
    logic [7:0]  map_first, map_second;
    logic [15:0] sense_value, touch_thresh, touch_hyst, prox_thresh;
    logic [15:0] prox_hyst;
    logic [1:0]  rpt_policy, buz_tone_one, buz_tone_two;
    logic [5:0]  idle_duty_first, idle_duty_second;
    logic [47:0] btn_duty;
    logic [4:0]  buz_ms_one, buz_ms_two;
    logic        sense_start, sense_window, led_drive, sleep_mode;
    logic        prox_status, report_valid, buzzer_out, buz_prev;
    logic        analog_output_first, analog_output_second;
    logic [3:0]  sense_chan;
    logic [7:0]  sense_combine, touch_status;
    logic [2:0]  report_btn;
    logic [143:0] slot_vals;
    int          num_errors, checks_done, frames, toggles, t0;
    int          pc, ha, hb, sa, sb;

    tsr_scan #(.MS_CYC(40), .TONE_HALF_1K(32)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .chan_enable(chan_enable),
        .prox_enable(prox_enable), .prox_combine(prox_combine),
        .sense_valid(sense_valid), .sense_value(sense_value),
        .touch_thresh(touch_thresh), .touch_hyst(touch_hyst),
        .prox_thresh(prox_thresh), .prox_hyst(prox_hyst),
        .active_skip(active_skip), .sleep_skip(sleep_skip),
        .sleep_enable(sleep_enable), .mode_force(mode_force),
        .mode_force_sleep(mode_force_sleep), .rpt_policy(rpt_policy),
        .rpt_idle_gap(rpt_idle_gap), .map_first(map_first),
        .map_second(map_second), .idle_duty_first(idle_duty_first),
        .idle_duty_second(idle_duty_second), .btn_duty(btn_duty),
        .buz_enable(buz_enable), .buz_idle_level(buz_idle_level),
        .buz_tone_one(buz_tone_one), .buz_tone_two(buz_tone_two),
        .buz_ms_one(buz_ms_one), .buz_ms_two(buz_ms_two),
        .sense_start(sense_start), .sense_chan(sense_chan),
        .sense_window(sense_window), .sense_combine(sense_combine),
        .led_drive(led_drive), .sleep_mode(sleep_mode),
        .touch_status(touch_status), .prox_status(prox_status),
        .report_valid(report_valid), .report_btn(report_btn),
        .analog_output_first(analog_output_first),
        .analog_output_second(analog_output_second),
        .buzzer_out(buzzer_out));

    tsr_frontend_model #(.DELAY(5)) frontend (
        .ref_clk(ref_clk), .arst_n(arst_n), .sense_start(sense_start),
        .sense_chan(sense_chan), .sense_window(sense_window),
        .slot_vals(slot_vals), .sense_valid(sense_valid),
        .sense_value(sense_value));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic set_val(input int k, input logic [15:0] v);
        @(posedge ref_clk);
        slot_vals[16*k +: 16] <= v;
    endtask

    task automatic next_frame();
        int f;
        f = frames;
        for (int i = 0; i < 40000 && frames == f; i++) @(negedge ref_clk);
        if (frames == f) begin
            num_errors++;
            conclude();
        end
        cyc(1400);
    endtask

    // pwm high time over each full period, buzzer edge count
    always @(posedge ref_clk) begin
        if (buzzer_out !== buz_prev) toggles++;
        buz_prev = buzzer_out;
        ha += int'(analog_output_first === 1'b1);
        hb += int'(analog_output_second === 1'b1);
        pc++;
        if (pc == PWM_PER) begin
            sa = ha;
            sb = hb;
            ha = 0;
            hb = 0;
            pc = 0;
        end
    end

    // slot walker: checks order and interval lengths of every sensed slot after the first
    initial begin : walker
        int k;
        int n;
        int ok;
        @(posedge arst_n);
        cyc(3);
        k = 1;
        forever begin
            ok = int'(sense_start === 1'b1);
            // a sleep skip frame holds no sensing slot at all
            for (int i = 0; i < 20100 && ok == 0; i++) begin
                @(negedge ref_clk);
                ok = int'(sense_start === 1'b1);
            end
            if (ok == 0) begin
                num_errors++;
                conclude();
            end
            chk("slot index", k, sense_chan);
            chk("combine", (k == 8) ? prox_combine : 8'h00, sense_combine);
            n = 0;
            while (sense_window === 1'b1 && n < 3000) begin
                n++;
                @(negedge ref_clk);
            end
            chk("sense length", SENSE_CYC, n);
            n = 0;
            while (led_drive === 1'b1 && n < 3000) begin
                n++;
                @(negedge ref_clk);
            end
            chk("led length", LED_CYC, n);
            if (k == 8) frames++;
            k = (k + 1) % 9;
        end
    end

    initial begin
        arst_n = 1'b0;
        chan_enable = 8'hff;
        prox_enable = 1'b1;
        prox_combine = 8'hff;
        touch_thresh = 16'h0064;
        touch_hyst = 16'h000a;
        prox_thresh = 16'h03e8;
        prox_hyst = 16'h000a;
        active_skip = 8'h00;
        sleep_skip = 8'h01;
        sleep_enable = 1'b1;
        mode_force = 1'b0;
        mode_force_sleep = 1'b0;
        rpt_policy = RPT_SINGLE;
        rpt_idle_gap = 1'b0;
        map_first = 8'hff;
        map_second = 8'h00;
        idle_duty_first = 6'h05;
        idle_duty_second = 6'h07;
        for (int b = 0; b < N_BTN; b++) btn_duty[6*b +: 6] = 6'(8 + 6 * b);
        buz_enable = 1'b1;
        buz_idle_level = 1'b0;
        buz_tone_one = 2'h0;
        buz_tone_two = 2'h0;
        buz_ms_one = 5'h05;
        buz_ms_two = 5'h05;
        slot_vals = '0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        next_frame();
        chk("touch", 32'h0000_0000, touch_status);
        chk("report valid", 32'h0000_0000, report_valid);
        chk("pwm first", 32'h0000_0032, sa);
        chk("pwm second", 32'h0000_0046, sb);
        chk("sleep", 32'h0000_0001, sleep_mode);
        chk("skip led", 32'h0000_0001, led_drive);
        cyc(1100);
        chk("skip window", 32'h0000_0000, sense_window);
        chk("skip slot", 32'h0000_0001, sense_chan);
        set_val(2, 16'h006e);
        set_val(5, 16'h00c8);
        set_val(8, 16'h07d0);
        t0 = toggles;
        next_frame();
        chk("touch", 32'h0000_0024, touch_status);
        chk("prox", 32'h0000_0001, prox_status);
        chk("woke", 32'h0000_0000, sleep_mode);
        chk("report valid", 32'h0000_0001, report_valid);
        chk("report btn", 32'h0000_0002, report_btn);
        chk("pwm first", 32'h0000_00c8, sa);
        chk("pwm second", 32'h0000_0046, sb);
        chk("tone played", 32'h0000_0001, (toggles - t0) >= 10);
        chk("buzzer rest", 32'h0000_0000, buzzer_out);
        set_val(2, 16'h005a);
        t0 = toggles;
        next_frame();
        chk("touch", 32'h0000_0024, touch_status);
        chk("report btn", 32'h0000_0002, report_btn);
        chk("tone again", 32'h0000_0000, toggles - t0);
        set_val(2, 16'h0059);
        next_frame();
        chk("touch", 32'h0000_0020, touch_status);
        chk("report btn", 32'h0000_0005, report_btn);
        chk("pwm first", 32'h0000_017c, sa);
        @(posedge ref_clk);
        rpt_policy <= RPT_ALL;
        cyc(1400);
        chk("report valid", 32'h0000_0000, report_valid);
        chk("pwm first", 32'h0000_0000, sa);
        chk("pwm second", 32'h0000_0000, sb);
        @(posedge ref_clk);
        mode_force <= 1'b1;
        mode_force_sleep <= 1'b1;
        cyc(3);
        chk("forced sleep", 32'h0000_0001, sleep_mode);
        @(posedge ref_clk);
        mode_force_sleep <= 1'b0;
        cyc(3);
        chk("forced active", 32'h0000_0000, sleep_mode);
        conclude();
    end
endmodule // tsr_scan_tb_top

//--- design/tsr_pkg.sv
// shared constants and types of the touch scan and report block
package tsr_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned SENSE_US    = 50;
    localparam int unsigned LED_US      = 50;
    localparam int unsigned SENSE_CYC   = (CLK_HZ / 1_000_000) * SENSE_US;
    localparam int unsigned LED_CYC     = (CLK_HZ / 1_000_000) * LED_US;
    localparam logic [10:0] SENSE_LAST  = 11'(SENSE_CYC - 1);
    localparam logic [10:0] LED_LAST    = 11'(LED_CYC - 1);
    localparam int unsigned PWM_HZ      = 2_000_000;
    localparam logic [3:0]  PWM_LAST    = 4'(CLK_HZ / PWM_HZ - 1);
    localparam int unsigned MS_PER_SEC  = 1000;
    localparam int unsigned MS_CYC_DEF  = CLK_HZ / MS_PER_SEC;
    localparam int unsigned TONE_BASE_HZ = 1000;
    localparam int unsigned TONE_HALF_DEF = CLK_HZ / (2 * TONE_BASE_HZ);
    // frame layout
    localparam int unsigned N_BTN       = 8;
    localparam logic [3:0]  PROX_SLOT   = 4'h8;
    // buzzer phase limits in ms
    localparam logic [4:0]  BUZ_MIN_MS  = 5'h05;
    localparam logic [4:0]  BUZ_MAX_MS  = 5'h1e;
    // reporting policies
    localparam logic [1:0]  RPT_ALL     = 2'h0;
    localparam logic [1:0]  RPT_SINGLE  = 2'h1;
    localparam logic [1:0]  RPT_STRONG  = 2'h2;

    typedef enum logic {SCAN_SENSE, SCAN_LED} tsr_phase_t;
    typedef enum logic [1:0] {BZ_IDLE, BZ_ONE, BZ_TWO} tsr_buz_t;
endpackage

//--- design/tsr_scan.sv
// scan sequencer, touch detection, reporting, pwm outputs and buzzer
// What this block does
// - a frame holds nine slots: eight buttons and one proximity slot
// - every slot is walked even if disabled, so frame length is fixed
// - each sensing slot is followed by an led drive interval
// - skip frames omit sensing but keep the led drive timing
// - scan period is one sensing frame plus the inserted skip frames
// - active mode uses its own short programmable scan period
// - sleep mode uses its own longer programmable scan period
// - with sleep enabled, a frame with no touch or proximity enters sleep
// - a touch or proximity while asleep returns to active mode
// - host may force the operating mode and the device obeys
// - touch at threshold plus hysteresis, release below threshold minus it
// - proximity slot senses combined inputs and gives an on/off state
// - a touch while the buzzer is idle plays a two phase square wave tone on the buzzer
// - the tone plays at most once per touch, never repeated while held
// - buzzer enable, idle level, tones and durations are settable
// - each analog output is a pwm with a six bit duty setting
// - idle duty when no mapped button reported, else that button's duty
// - each output reports one button; buttons map to either or both
// - policies all, single, strongest; all leaves analog outputs off
// - single keeps first touch; on release next shown now or after idle
// - touches in the same scan period: lowest index wins, except under strongest
// - strongest switches only to a stronger touch
// - phase durations 5 to 30 ms, tones 1, 2, 4 or 8 khz
module tsr_scan
    import tsr_pkg::*;
#(
    parameter int unsigned MS_CYC       = MS_CYC_DEF,
    parameter int unsigned TONE_HALF_1K = TONE_HALF_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  chan_enable,
    input  wire logic        prox_enable,
    input  wire logic [7:0]  prox_combine,
    input  wire logic        sense_valid,
    input  wire logic [15:0] sense_value,
    input  wire logic [15:0] touch_thresh,
    input  wire logic [15:0] touch_hyst,
    input  wire logic [15:0] prox_thresh,
    input  wire logic [15:0] prox_hyst,
    input  wire logic [7:0]  active_skip,
    input  wire logic [7:0]  sleep_skip,
    input  wire logic        sleep_enable,
    input  wire logic        mode_force,
    input  wire logic        mode_force_sleep,
    input  wire logic [1:0]  rpt_policy,
    input  wire logic        rpt_idle_gap,
    input  wire logic [7:0]  map_first,
    input  wire logic [7:0]  map_second,
    input  wire logic [5:0]  idle_duty_first,
    input  wire logic [5:0]  idle_duty_second,
    input  wire logic [47:0] btn_duty,
    input  wire logic        buz_enable,
    input  wire logic        buz_idle_level,
    input  wire logic [1:0]  buz_tone_one,
    input  wire logic [1:0]  buz_tone_two,
    input  wire logic [4:0]  buz_ms_one,
    input  wire logic [4:0]  buz_ms_two,
    output logic             sense_start,
    output logic [3:0]       sense_chan,
    output logic             sense_window,
    output logic [7:0]       sense_combine,
    output logic             led_drive,
    output logic             sleep_mode,
    output logic [7:0]       touch_status,
    output logic             prox_status,
    output logic             report_valid,
    output logic [2:0]       report_btn,
    output logic             analog_output_first,
    output logic             analog_output_second,
    output logic             buzzer_out
);
    if (MS_CYC < 16 || MS_CYC > 32767) begin : g_ms_chk
        $error("MS_CYC out of range for the 15 bit ms counter");
    end
    if (TONE_HALF_1K < 16 || TONE_HALF_1K > 16383) begin : g_tone_chk
        $error("TONE_HALF_1K out of range for the 14 bit tone counter");
    end

    localparam logic [14:0] MS_LAST   = 15'(MS_CYC - 1);
    localparam logic [13:0] TONE_HALF = 14'(TONE_HALF_1K);

    typedef struct packed {
        tsr_phase_t      ph;
        logic [3:0]      slot;
        logic [10:0]     tcnt;
        logic            skip_fr;
        logic [7:0]      skip_left;
        logic            sleep;
        logic            act;
        logic [7:0]      touched;
        logic [7:0][15:0] str;
        logic            prox;
        logic            rep_v;
        logic [2:0]      rep;
        tsr_buz_t        bz;
        logic [14:0]     ms_cnt;
        logic [4:0]      ms_left;
        logic [13:0]     tn_cnt;
        logic            buz;
        logic [3:0]      pdiv;
        logic [5:0]      pcnt;
        logic            ao1;
        logic            ao2;
        logic            start;
    } tsr_state_t;
    tsr_state_t st_q;
    tsr_state_t st_d;
    // hysteresis decision shared by buttons and proximity
    function automatic logic hyst_next(input logic cur, input logic [15:0] v,
                                       input logic [15:0] thr,
                                       input logic [15:0] hy);
        logic [16:0] hi;
        logic [16:0] lo;
        hi = {1'b0, thr} + {1'b0, hy};
        lo = (thr > hy) ? {1'b0, thr - hy} : 17'h0_0000;
        if (!cur)
            return ({1'b0, v} >= hi);
        else
            return !({1'b0, v} < lo);
    endfunction

    // phase duration clamped into the legal window
    function automatic logic [4:0] clamp_ms(input logic [4:0] ms);
        if (ms < BUZ_MIN_MS)
            return BUZ_MIN_MS;
        else if (ms > BUZ_MAX_MS)
            return BUZ_MAX_MS;
        else
            return ms;
    endfunction
    function automatic logic [5:0] duty_of(input logic [2:0] b,
                                           input logic [47:0] tab);
        return tab[6*b +: 6];
    endfunction

    logic       frame_end;
    logic       new_touch;
    logic [2:0] low_idx;
    logic [2:0] strong_idx;
    logic [7:0] skip_now;
    logic       pwm_wrap;
    always_comb begin
        st_d      = st_q;
        st_d.start = 1'b0;
        frame_end = (st_q.ph == SCAN_LED) && (st_q.tcnt == LED_LAST)
                    && (st_q.slot == PROX_SLOT);
        low_idx    = 3'h0;
        strong_idx = 3'h0;
        for (int i = N_BTN - 1; i >= 0; i--) begin
            if (st_q.touched[i])
                low_idx = 3'(i);
        end
        for (int i = 0; i < N_BTN; i++) begin
            if (st_q.touched[i] && (!st_q.touched[strong_idx]
                || st_q.str[i] > st_q.str[strong_idx]))
                strong_idx = 3'(i);
        end

        st_d.tcnt = st_q.tcnt + 11'h001;
        if (st_q.ph == SCAN_SENSE && st_q.tcnt == SENSE_LAST) begin
            st_d.ph   = SCAN_LED;
            st_d.tcnt = 11'h000;
        end else if (st_q.ph == SCAN_LED && st_q.tcnt == LED_LAST) begin
            st_d.ph    = SCAN_SENSE;
            st_d.tcnt  = 11'h000;
            st_d.slot  = (st_q.slot == PROX_SLOT) ? 4'h0 : st_q.slot + 4'h1;
            st_d.start = 1'b1;
        end

        new_touch = 1'b0;
        if (st_q.ph == SCAN_SENSE && !st_q.skip_fr && sense_valid) begin
            if (st_q.slot == PROX_SLOT) begin
                st_d.prox = prox_enable
                    && hyst_next(st_q.prox, sense_value, prox_thresh, prox_hyst);
            end else begin
                st_d.touched[st_q.slot[2:0]] = chan_enable[st_q.slot[2:0]]
                    && hyst_next(st_q.touched[st_q.slot[2:0]], sense_value,
                                 touch_thresh, touch_hyst);
                st_d.str[st_q.slot[2:0]] = sense_value;
                new_touch = st_d.touched[st_q.slot[2:0]]
                            && !st_q.touched[st_q.slot[2:0]];
            end
        end
        st_d.act = st_q.act | (|st_d.touched) | st_d.prox;

        if (mode_force)
            st_d.sleep = mode_force_sleep;

        skip_now = 8'h00;
        if (frame_end) begin
            st_d.act = 1'b0;
            if (!st_q.skip_fr) begin
                if (!mode_force) begin
                    if (st_q.sleep && st_q.act)
                        st_d.sleep = 1'b0;
                    else if (!st_q.sleep && sleep_enable && !st_q.act)
                        st_d.sleep = 1'b1;
                end
                skip_now = st_d.sleep ? sleep_skip : active_skip;
                if (!st_q.rep_v || !st_q.touched[st_q.rep]) begin
                    if (st_q.rep_v && rpt_idle_gap) begin
                        st_d.rep_v = 1'b0;
                    end else begin
                        st_d.rep_v = |st_q.touched;
                        st_d.rep = (rpt_policy == RPT_STRONG) ? strong_idx
                                                              : low_idx;
                    end
                end else if (rpt_policy == RPT_STRONG
                             && st_q.str[strong_idx] > st_q.str[st_q.rep]) begin
                    st_d.rep_v = !rpt_idle_gap;
                    st_d.rep   = strong_idx;
                end
            end else begin
                skip_now = st_q.skip_left - 8'h01;
            end
            // the programmed number of skip frames, if any, follows each sensing frame
            st_d.skip_left = skip_now;
            st_d.skip_fr   = (skip_now != 8'h00);
        end

        st_d.ms_cnt = st_q.ms_cnt + 15'h0001;
        st_d.tn_cnt = st_q.tn_cnt + 14'h0001;
        case (st_q.bz)
            BZ_IDLE: begin
                st_d.buz = buz_idle_level;
                if (new_touch && buz_enable) begin
                    st_d.bz      = BZ_ONE;
                    st_d.ms_cnt  = 15'h0000;
                    st_d.tn_cnt  = 14'h0000;
                    st_d.ms_left = clamp_ms(buz_ms_one);
                    st_d.buz     = !buz_idle_level;
                end
            end
            BZ_ONE, BZ_TWO: begin
                if (st_q.tn_cnt == (TONE_HALF >> (st_q.bz == BZ_ONE
                        ? buz_tone_one : buz_tone_two)) - 14'h0001) begin
                    st_d.tn_cnt = 14'h0000;
                    st_d.buz    = !st_q.buz;
                end
                if (st_q.ms_cnt == MS_LAST) begin
                    st_d.ms_cnt  = 15'h0000;
                    st_d.ms_left = st_q.ms_left - 5'h01;
                    if (st_q.ms_left == 5'h01) begin
                        st_d.tn_cnt = 14'h0000;
                        if (st_q.bz == BZ_ONE) begin
                            st_d.bz      = BZ_TWO;
                            st_d.ms_left = clamp_ms(buz_ms_two);
                        end else begin
                            st_d.bz  = BZ_IDLE;
                            st_d.buz = buz_idle_level;
                        end
                    end
                end
            end
            default: begin
                st_d.bz = BZ_IDLE;
            end
        endcase
        if (!buz_enable) begin
            st_d.bz  = BZ_IDLE;
            st_d.buz = buz_idle_level;
        end

        // 64 step pwm at 2 mhz
        pwm_wrap = (st_q.pdiv == PWM_LAST);
        st_d.pdiv = pwm_wrap ? 4'h0 : st_q.pdiv + 4'h1;
        if (pwm_wrap)
            st_d.pcnt = st_q.pcnt + 6'h01;
        st_d.ao1 = 1'b0;
        st_d.ao2 = 1'b0;
        if (rpt_policy != RPT_ALL) begin
            st_d.ao1 = st_q.pcnt < ((st_q.rep_v && map_first[st_q.rep])
                ? duty_of(st_q.rep, btn_duty) : idle_duty_first);
            st_d.ao2 = st_q.pcnt < ((st_q.rep_v && map_second[st_q.rep])
                ? duty_of(st_q.rep, btn_duty) : idle_duty_second);
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= '0;
            st_q.ph    <= SCAN_SENSE;
            st_q.bz    <= BZ_IDLE;
            st_q.start <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sense_start   = st_q.start && !st_q.skip_fr;
    assign sense_chan    = st_q.slot;
    assign sense_window  = (st_q.ph == SCAN_SENSE) && !st_q.skip_fr;
    assign sense_combine = (st_q.slot == PROX_SLOT && prox_enable)
                           ? prox_combine : 8'h00;
    assign led_drive     = (st_q.ph == SCAN_LED);
    assign sleep_mode    = st_q.sleep;
    assign touch_status  = st_q.touched;
    assign prox_status   = st_q.prox;
    assign report_valid  = st_q.rep_v && (rpt_policy != RPT_ALL);
    assign report_btn    = st_q.rep;
    assign analog_output_first  = st_q.ao1;
    assign analog_output_second = st_q.ao2;
    assign buzzer_out    = st_q.buz;
    frame_slots_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n) st_q.slot <= PROX_SLOT)
        else $error("slot index beyond the proximity slot");
    slot_order_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q.ph == SCAN_LED && st_q.tcnt == LED_LAST) |=>
        st_q.ph == SCAN_SENSE && st_q.slot ==
        (($past(st_q.slot) == PROX_SLOT) ? 4'h0 : $past(st_q.slot) + 4'h1))
        else $error("slot did not advance in rotation");
    led_length_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(led_drive) |-> $past(st_q.tcnt) == LED_LAST)
        else $error("led interval wrong length");
    skip_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        st_q.skip_fr |-> !sense_start && !sense_window)
        else $error("sensing during a skip frame");
    sleep_entry_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (frame_end && !st_q.skip_fr && !mode_force && sleep_enable
         && !st_q.sleep && !st_q.act) |=> sleep_mode)
        else $error("idle frame did not enter sleep");
    wake_up_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (frame_end && !st_q.skip_fr && !mode_force && st_q.sleep && st_q.act)
        |=> !sleep_mode)
        else $error("activity did not wake the device");
    forced_mode_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        mode_force ##1 mode_force |-> sleep_mode == $past(mode_force_sleep))
        else $error("forced mode not held");
    touch_detect_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (sense_window && sense_valid && st_q.slot != PROX_SLOT
         && chan_enable[st_q.slot[2:0]]
         && {1'b0, sense_value} >= {1'b0, touch_thresh} + {1'b0, touch_hyst})
        |=> touch_status[$past(st_q.slot[2:0])])
        else $error("value above upper threshold not seen as touch");
    buzzer_idle_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        ($past(arst_n) && st_q.bz == BZ_IDLE && $past(st_q.bz) == BZ_IDLE
         && $stable(buz_idle_level)) |-> buzzer_out == buz_idle_level)
        else $error("buzzer not at idle level");
    all_policy_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        $past(rpt_policy) == RPT_ALL |->
        !analog_output_first && !analog_output_second)
        else $error("analog output active in all policy");
    pwm_period_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q.pcnt == 6'h3f && pwm_wrap) |=> st_q.pcnt == 6'h00)
        else $error("pwm period not 64 steps");
endmodule // tsr_scan
